// file: inc/rcg_pkg.sv
// reset and clock generation: shared constants, register map, field layout
// assumes one core clock at 100 MHz; pixel clock synthesis is modelled
package rcg_pkg;
	// clock and timing
	localparam int unsigned CLK_MHZ          = 100;
	localparam int unsigned REF_KHZ          = 14318;
	localparam int unsigned RST_DELAY_US     = 100;
	// reference cycles for the release delay (rounded up)
	localparam int unsigned RST_DELAY_CYC    =
		(RST_DELAY_US * REF_KHZ + 999) / 1000;
	localparam int unsigned POR_MIN_US       = 100;
	localparam int unsigned PLL_SETTLE_US    = 500;
	localparam int unsigned PLL_SETTLE_CYC   = PLL_SETTLE_US * CLK_MHZ;
	// frequency limits in MHz, legacy limit in kHz
	localparam int unsigned LEG_MAX_KHZ      = 8330;
	localparam int unsigned PIX_MIN_MHZ      = 10;
	localparam int unsigned PIX_MAX_MHZ      = 200;
	localparam int unsigned PIX_GFX_MAX_MHZ  = 150;
	localparam int unsigned VCO_MIN_MHZ      = 140;
	localparam int unsigned VCO_MAX_MHZ      = 300;

	// register map (byte offsets)
	localparam logic [7:0] TIMER_CTRL_LEGACY_CLOCK_DIVIDER_OFF = 8'h50;
	localparam logic [7:0] TIMER_CTRL_RST_VAL = 8'h7B;
	localparam logic [7:0] PIXEL_CFG_OFF      = 8'h24;
	localparam logic [31:0] PIXEL_CFG_RST_VAL = 32'h00000000;
	localparam logic [7:0] STATUS_OFF         = 8'h60;

	// legacy divisor field
	localparam int unsigned LDIV_LSB = 0;
	localparam int unsigned LDIV_W   = 3;
	localparam logic [2:0] LDIV_RSVD = 3'h0;
	localparam logic [2:0] LDIV_DIV3 = 3'h2;
	localparam logic [2:0] LDIV_DIV4 = 3'h3;

	// pixel config fields
	localparam int unsigned PC_FB_RESET = 31;
	localparam int unsigned PC_HALF_DIS = 30;
	localparam int unsigned PC_PD_MSB   = 28;
	localparam int unsigned PC_PD_LSB   = 24;
	localparam int unsigned PC_PLUS1    = 23;
	localparam int unsigned PC_N_MSB    = 22;
	localparam int unsigned PC_N_LSB    = 12;
	localparam int unsigned PC_CLK_ON   = 11;
	localparam int unsigned PC_BYPASS   = 8;
	localparam int unsigned PC_ID_MSB   = 2;
	localparam int unsigned PC_ID_LSB   = 0;
	localparam logic [31:0] PC_WMASK    = 32'hDFFFF907;
	localparam logic [4:0] PD_ONE_CODE  = 5'h0F;
	localparam logic [4:0] PD_RSVD_CODE = 5'h1F;

	// legacy code to divide value
	function automatic logic [3:0] rcg_leg_div(input logic [2:0] code);
		rcg_leg_div = {1'b0, code} + 4'h1;
	endfunction : rcg_leg_div

	// input divider code to divide value (2..9), per printed table
	function automatic logic [3:0] rcg_in_div(input logic [2:0] code);
		case (code)
			3'h0: rcg_in_div = 4'h2;
			3'h1: rcg_in_div = 4'h3;
			3'h2: rcg_in_div = 4'h4;
			3'h3: rcg_in_div = 4'h5;
			3'h4: rcg_in_div = 4'h6;
			3'h5: rcg_in_div = 4'h7;
			3'h6: rcg_in_div = 4'h8;
			default: rcg_in_div = 4'h9;
		endcase
	endfunction : rcg_in_div

	// post divider code to divide value, zero for reserved
	function automatic logic [4:0] rcg_post_div(input logic [4:0] code);
		logic [4:0] t [32];
		t = '{5'd8, 5'd6, 5'd18, 5'd4, 5'd12, 5'd16, 5'd24, 5'd2,
			5'd10, 5'd20, 5'd14, 5'd26, 5'd22, 5'd28, 5'd30, 5'd1,
			5'd9, 5'd7, 5'd19, 5'd5, 5'd13, 5'd17, 5'd25, 5'd3,
			5'd11, 5'd21, 5'd15, 5'd27, 5'd23, 5'd29, 5'd31, 5'd0};
		rcg_post_div = t[code];
	endfunction : rcg_post_div
endpackage : rcg_pkg

// file: inc/rcg_if.sv
// reset and clock generation link between device and system party
// assumes both ends share core_clk; cpu_rst is active high, por_n and pci_rst_n are active low
`timescale 1ns/1ns
interface rcg_if;
	logic        por_n;
	logic        ref_clk_en;
	logic        pci_rst_n;
	logic        cpu_rst;
	logic        legacy_bus_clock;
	logic        pixel_clock;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;

	modport dev (
		input  por_n, ref_clk_en, reg_wr, reg_rd, reg_addr, reg_wdata,
		output pci_rst_n, cpu_rst, legacy_bus_clock, pixel_clock, reg_rdata
	);
	modport sys (
		output por_n, ref_clk_en, reg_wr, reg_rd, reg_addr, reg_wdata,
		input  pci_rst_n, cpu_rst, legacy_bus_clock, pixel_clock, reg_rdata
	);
endinterface : rcg_if

// file: hw/rcg_dev.sv
// reset and clock generation device end
// assumes core_clk stands in for the pci clock; reference clock arrives
// as a one-cycle enable pulse; por_n and ref_clk_en are synchronised here
// limitation: the pixel clock is a toggle model, not a real pll
`timescale 1ns/1ns
module rcg_dev
	import rcg_pkg::*;
#(
	parameter int unsigned RST_CYC = RST_DELAY_CYC
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// link
	rcg_if.dev               lnk,
	// user side: decoded pll settings, pll running flag and legacy divisor invalid flag
	output logic [3:0]        pll_input_divider,
	output logic [11:0]       pll_feedback_divider,
	output logic [4:0]        pll_post_divider,
	output logic              pll_running,
	output logic              leg_div_invalid
);
	// all state in one record; always_comb builds the next copy
	typedef struct packed {
		logic [1:0]  por_sync;
		logic [1:0]  ref_sync;
		logic        ref_prev;
		logic [15:0] rst_cnt;
		logic        rst_out;
		logic [7:0]  leg_reg;
		logic [3:0]  leg_cnt;
		logic        leg_clk;
		logic [31:0] pix_cfg;
		logic [11:0] fb_acc;
		logic        pix_clk;
		logic [31:0] rdata;
	} rcg_dev_s;

	rcg_dev_s st_q;
	rcg_dev_s st_d;
	logic     ref_tick;
	logic [3:0]  ldiv;
	logic [3:0]  idv;
	logic [11:0] fdv;
	logic [4:0]  pdv;
	logic [12:0] fb_sum;
	logic        pll_ok;
	logic [8:0]  div_prod;
	logic        leg_off;
	logic [31:0] status_w;

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// reserved legacy code parks the clock rather than guess a ratio
	function automatic logic leg_code_rsvd(input logic [7:0] r);
		leg_code_rsvd = r[LDIV_W-1:0] == LDIV_RSVD;
	endfunction : leg_code_rsvd

	// -----------------------------------------------------------------
	// decode
	// -----------------------------------------------------------------
	// reference idles low and the edge flop resets low: no false tick
	assign ref_tick = st_q.ref_sync[1] & ~st_q.ref_prev;
	assign ldiv = rcg_leg_div(st_q.leg_reg[LDIV_W-1:0]);
	assign idv  = rcg_in_div(st_q.pix_cfg[PC_ID_MSB:PC_ID_LSB]);
	assign fdv  = {st_q.pix_cfg[PC_N_MSB:PC_N_LSB], 1'b0}
		| {11'h000, st_q.pix_cfg[PC_PLUS1]};
	assign pdv  = rcg_post_div(st_q.pix_cfg[PC_PD_MSB:PC_PD_LSB]);
	// pll runs when enabled or pd is one, not held in feedback reset, with legal pd and nonzero fd
	assign pll_ok = (st_q.pix_cfg[PC_CLK_ON]
		|| st_q.pix_cfg[PC_PD_MSB:PC_PD_LSB] == PD_ONE_CODE)
		&& !st_q.pix_cfg[PC_FB_RESET] && pdv != 5'h00
		&& fdv != 12'h000;
	assign fb_sum = {1'b0, st_q.fb_acc} + {1'b0, fdv};
	// widen both factors first: id 9 times pd 31 needs nine bits
	assign div_prod = {5'h00, idv} * {4'h0, pdv};
	assign leg_off  = leg_code_rsvd(st_q.leg_reg);
	// status word: bit0 reserved legacy code, bit1 resets held,
	// bit2 pll running
	assign status_w = {29'h0, pll_ok, st_q.rst_out, leg_off};

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.por_sync = {st_q.por_sync[0], lnk.por_n};
		st_d.ref_sync = {st_q.ref_sync[0], lnk.ref_clk_en};
		st_d.ref_prev = st_q.ref_sync[1];

		// reset release counted in reference cycles; a new power-on
		// pulse clears the count, so a short glitch restarts the delay
		if (!st_q.por_sync[1]) begin
			st_d.rst_cnt = 16'h0000;
			st_d.rst_out = 1'b1;
		end else if (st_q.rst_out && ref_tick) begin
			if (st_q.rst_cnt >= 16'(RST_CYC - 1))
				st_d.rst_out = 1'b0;
			else
				st_d.rst_cnt = st_q.rst_cnt + 16'h0001;
		end

		// legacy clock: high in the second half of each period,
		// parked low by the reserved code; a new code acts at once,
		// so the first period after a write may come out short
		if (leg_off) begin
			st_d.leg_cnt = 4'h0;
			st_d.leg_clk = 1'b0;
		end else if (st_q.leg_cnt >= ldiv - 4'h1) begin
			st_d.leg_cnt = 4'h0;
			st_d.leg_clk = 1'b0;
		end else begin
			st_d.leg_cnt = st_q.leg_cnt + 4'h1;
			if (st_q.leg_cnt == (ldiv >> 1) - 4'h1)
				st_d.leg_clk = 1'b1;
		end

		// pixel clock: phase accumulator adds fd per reference tick and
		// toggles after pd*id, giving ref*fd/(2*pd*id); bypass passes ref
		// bypass hands the reference through while the pll settles
		if (st_q.pix_cfg[PC_BYPASS]) begin
			st_d.pix_clk = st_q.ref_sync[1];
			st_d.fb_acc  = 12'h000;
		end else if (!pll_ok) begin
			st_d.pix_clk = 1'b0;
			st_d.fb_acc  = 12'h000;
		end else if (ref_tick) begin
			// limitation: one toggle per tick at most, so feedback
			// above id*pd lies outside what this model can follow
			if (fb_sum >= {4'h0, div_prod}) begin
				st_d.fb_acc  = 12'(fb_sum - {4'h0, div_prod});
				st_d.pix_clk = ~st_q.pix_clk;
			end else begin
				st_d.fb_acc = fb_sum[11:0];
			end
		end

		// register writes; unmapped offsets are dropped without trace
		if (lnk.reg_wr) begin
			case (lnk.reg_addr)
				TIMER_CTRL_LEGACY_CLOCK_DIVIDER_OFF:
					st_d.leg_reg = lnk.reg_wdata[7:0];
				PIXEL_CFG_OFF:
					st_d.pix_cfg = lnk.reg_wdata & PC_WMASK;
				default: ;
			endcase
		end

		// register reads, data in the next cycle only
		st_d.rdata = 32'h00000000;
		if (lnk.reg_rd) begin
			case (lnk.reg_addr)
				TIMER_CTRL_LEGACY_CLOCK_DIVIDER_OFF:
					st_d.rdata = {24'h000000, st_q.leg_reg};
				PIXEL_CFG_OFF:  st_d.rdata = st_q.pix_cfg;
				STATUS_OFF:     st_d.rdata = status_w;
				default:        st_d.rdata = 32'h00000000;
			endcase
		end
	end

	// synchronous reset loads constants only; resets come up asserted
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q          <= '0;
			st_q.rst_out  <= 1'b1;
			st_q.leg_reg  <= TIMER_CTRL_RST_VAL;
			st_q.pix_cfg  <= PIXEL_CFG_RST_VAL;
		end else begin
			st_q <= st_d;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	// both resets come from one flop so they can never disagree
	assign lnk.pci_rst_n        = ~st_q.rst_out;
	assign lnk.cpu_rst          = st_q.rst_out;
	assign lnk.legacy_bus_clock = st_q.leg_clk;
	assign lnk.pixel_clock      = st_q.pix_clk;
	assign lnk.reg_rdata        = st_q.rdata;
	assign pll_input_divider    = idv;
	assign pll_feedback_divider = fdv;
	assign pll_post_divider     = pdv;
	assign pll_running          = pll_ok;
	assign leg_div_invalid      = leg_off;
endmodule : rcg_dev

// file: hw/rcg_sys.sv
// reset and clock generation system end: drives power-on reset and
// reference enable, and forwards software register requests
// assumes the device end on the same core_clk
`timescale 1ns/1ns
module rcg_sys
	import rcg_pkg::*;
#(
	parameter int unsigned POR_CYC = POR_MIN_US * CLK_MHZ,
	parameter int unsigned REF_DIV = 7
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// link
	rcg_if.sys               lnk,
	// software port
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	input  wire logic [7:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	output logic [31:0]      sw_rdata,
	// status
	output logic             sys_in_reset,
	output logic             por_done
);
	typedef struct packed {
		logic [15:0] por_cnt;
		logic        por_n;
		logic [3:0]  ref_cnt;
		logic        ref_en;
		logic [1:0]  rst_sync;
	} rcg_sys_s;

	rcg_sys_s st_q;
	rcg_sys_s st_d;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// reference runs in every state, including power-on reset
		if (st_q.ref_cnt >= 4'(REF_DIV - 1)) begin
			st_d.ref_cnt = 4'h0;
			st_d.ref_en  = 1'b1;
		end else begin
			st_d.ref_cnt = st_q.ref_cnt + 4'h1;
			st_d.ref_en  = 1'b0;
		end
		// hold power-on reset for its minimum width
		if (st_q.por_cnt >= 16'(POR_CYC - 1))
			st_d.por_n = 1'b1;
		else
			st_d.por_cnt = st_q.por_cnt + 16'h0001;
		st_d.rst_sync = {st_q.rst_sync[0], lnk.cpu_rst};
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// software must honour divisor limits and the pll change sequence
	assign lnk.por_n      = st_q.por_n;
	assign lnk.ref_clk_en = st_q.ref_en;
	assign lnk.reg_wr     = sw_wr;
	assign lnk.reg_rd     = sw_rd;
	assign lnk.reg_addr   = sw_addr;
	assign lnk.reg_wdata  = sw_wdata;
	assign sw_rdata       = lnk.reg_rdata;
	assign sys_in_reset   = st_q.rst_sync[1];
	assign por_done       = st_q.por_n;
endmodule : rcg_sys

// file: test/rcg_monitor.sv
// checker for the link between the two reset and clock ends
// assumes it sits beside the interface; bounds suit a 4-tick delay
`timescale 1ns/1ns
module rcg_monitor
	import rcg_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// link
	input wire logic        por_n,
	input wire logic        pci_rst_n,
	input wire logic        cpu_rst,
	input wire logic        legacy_bus_clock,
	input wire logic        pixel_clock,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata
);
	localparam logic [7:0] LEG = TIMER_CTRL_LEGACY_CLOCK_DIVIDER_OFF;
	logic [7:0]  leg_q;
	logic [31:0] pix_q;
	logic [3:0]  cnt_q;
	logic [1:0]  ok_q;
	logic        lbc_q;
	logic        rise;
	logic        stop;
	assign rise = legacy_bus_clock && !lbc_q;
	// bypass wins over every stop cause
	assign stop = !pix_q[8] && (pix_q[31] || pix_q[28:24] == 5'h1F
		|| (!pix_q[11] && pix_q[28:24] != 5'h0F));
	// ----------
	// shadows
	// ----------
	// two edges after a divisor write before the period is trusted
	always_ff @(posedge core_clk) begin
		lbc_q <= legacy_bus_clock;
		cnt_q <= rise ? 4'h1 : cnt_q + {3'h0, cnt_q != 4'hF};
		if (rst) begin
			leg_q <= TIMER_CTRL_RST_VAL;
			pix_q <= PIXEL_CFG_RST_VAL;
			ok_q  <= 2'h0;
		end else if (reg_wr && reg_addr == LEG) begin
			leg_q <= reg_wdata[7:0];
			ok_q  <= 2'h0;
		end else begin
			if (reg_wr && reg_addr == PIXEL_CFG_OFF)
				pix_q <= reg_wdata & PC_WMASK;
			if (rise && ok_q != 2'h3)
				ok_q <= ok_q + 2'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_pair; cpu_rst == !pci_rst_n; endproperty
	a_pair: assert property (p_pair)
		else $error("reset outputs disagree");
	property p_hold; !por_n [*3] |-> cpu_rst; endproperty
	a_hold: assert property (p_hold)
		else $error("reset released during power-on reset");
	property p_rmin; $rose(por_n) |-> cpu_rst [*8]; endproperty
	a_rmin: assert property (p_rmin)
		else $error("reset released too early");
	property p_rmax; $rose(por_n) |-> ##[1:80] !cpu_rst; endproperty
	a_rmax: assert property (p_rmax)
		else $error("reset held too long");
	property p_per;
		rise && ok_q[1] |-> cnt_q == {1'b0, leg_q[2:0]} + 4'h1;
	endproperty
	a_per: assert property (p_per)
		else $error("legacy clock period wrong");
	property p_rdleg;
		reg_rd && reg_addr == LEG |=> reg_rdata == {24'h0, leg_q};
	endproperty
	a_rdleg: assert property (p_rdleg)
		else $error("divisor register read wrong");
	property p_rdpix;
		reg_rd && reg_addr == PIXEL_CFG_OFF |=> reg_rdata == pix_q;
	endproperty
	a_rdpix: assert property (p_rdpix)
		else $error("pixel config read wrong");
	property p_stop; stop [*4] |-> !pixel_clock; endproperty
	a_stop: assert property (p_stop)
		else $error("pixel clock runs while stopped");
endmodule : rcg_monitor

// file: test/testbench.sv
// bench joining the system end and the device end over the link
// assumes shortened counts: four reference ticks, 20-cycle power-on
`timescale 1ns/1ns
module testbench
	import rcg_pkg::*;
;
	localparam int RCYC = 4;
	localparam int PCYC = 20;
	localparam int RDIV = 7;
	localparam logic [7:0] LEG = TIMER_CTRL_LEGACY_CLOCK_DIVIDER_OFF;
	localparam logic [7:0] PIX = PIXEL_CFG_OFF;
	logic        core_clk = 1'b0;
	logic        rst      = 1'b1;
	logic        sw_wr    = 1'b0;
	logic        sw_rd    = 1'b0;
	logic [7:0]  sw_addr  = 8'h00;
	logic [31:0] sw_wdata = 32'h0;
	logic [31:0] sw_rdata;
	logic        sys_in_reset;
	logic        por_done;
	logic        leg_inv;
	logic [3:0]  p_id;
	logic [11:0] p_fd;
	logic [4:0]  p_pd;
	logic        p_run;
	int          m_leg;
	logic [31:0] m_pix;
	logic [31:0] exp_q [$];
	logic [31:0] rs = 32'h1B84;
	logic [31:0] v;
	logic [31:0] cfg;
	int          n_errors = 0;
	int          checked  = 0;
	int          tl;
	int          tp;
	int          k;
	int          fd;
	int          pe [4] = '{8, 2, 1, 0};
	logic [4:0]  pc [4] = '{5'h00, 5'h07, 5'h0F, 5'h1F};
	rcg_if lnk ();
	rcg_dev #(.RST_CYC(RCYC)) rcg_dev_inst (.core_clk(core_clk), .rst(rst),
		.lnk(lnk), .pll_input_divider(p_id), .pll_feedback_divider(p_fd),
		.pll_post_divider(p_pd), .pll_running(p_run),
		.leg_div_invalid(leg_inv));
	rcg_sys #(.POR_CYC(PCYC), .REF_DIV(RDIV)) rcg_sys_inst (
		.core_clk(core_clk), .rst(rst), .lnk(lnk), .sw_wr(sw_wr),
		.sw_rd(sw_rd), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_rdata(sw_rdata), .sys_in_reset(sys_in_reset),
		.por_done(por_done));
	rcg_monitor rcg_monitor_inst (.core_clk(core_clk), .rst(rst),
		.por_n(lnk.por_n), .pci_rst_n(lnk.pci_rst_n), .cpu_rst(lnk.cpu_rst),
		.legacy_bus_clock(lnk.legacy_bus_clock),
		.pixel_clock(lnk.pixel_clock), .reg_wr(lnk.reg_wr),
		.reg_rd(lnk.reg_rd), .reg_addr(lnk.reg_addr),
		.reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata));
	always #5 core_clk = ~core_clk;
	// ----------
	// helpers
	// ----------
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	// pll runs when enabled (or pd is one), out of feedback reset,
	// with a legal post code and a nonzero feedback value
	function automatic logic m_run(input logic [31:0] c);
		int f;
		f = 2 * int'(c[PC_N_MSB:PC_N_LSB]) + int'(c[PC_PLUS1]);
		return (c[PC_CLK_ON] || c[PC_PD_MSB:PC_PD_LSB] == PD_ONE_CODE)
			&& !c[PC_FB_RESET] && c[PC_PD_MSB:PC_PD_LSB] != PD_RSVD_CODE
			&& f != 0;
	endfunction : m_run
	// register model: every read comes after reset release
	function automatic logic [31:0] m_rd(input logic [7:0] a);
		if (a == LEG)
			return 32'(m_leg);
		if (a == PIX)
			return m_pix;
		if (a == STATUS_OFF)
			return {29'h0, m_run(m_pix), 1'b0, m_leg[2:0] == 3'h0};
		return 32'h0;
	endfunction : m_rd
	task automatic stop_test();
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic tmo(input int n);
		if (n >= 200) begin
			n_errors++;
			$display("unexpected at %0t: wait timed out", $time);
			stop_test();
		end
	endtask : tmo
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		sw_wr    <= 1'b1;
		sw_addr  <= a;
		sw_wdata <= d;
		@(posedge core_clk);
		sw_wr <= 1'b0;
		if (a == LEG)
			m_leg = int'(d[7:0]);
		else if (a == PIX)
			m_pix = d & PC_WMASK;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		exp_q.push_back(m_rd(a));
		sw_rd   <= 1'b1;
		sw_addr <= a;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		@(negedge core_clk);
		d = sw_rdata;
		chk(d, exp_q.pop_front());
	endtask : rd
	// toggles of both clocks over n cycles
	task automatic tog(input int n);
		logic pl;
		logic pp;
		tl = 0;
		tp = 0;
		repeat (n) begin
			pl = lnk.legacy_bus_clock;
			pp = lnk.pixel_clock;
			@(negedge core_clk);
			tl += int'(lnk.legacy_bus_clock !== pl);
			tp += int'(lnk.pixel_clock !== pp);
		end
	endtask : tog
	task automatic reset_seq();
		@(posedge core_clk);
		rst <= 1'b1;
		m_leg = int'(TIMER_CTRL_RST_VAL);
		m_pix = PIXEL_CFG_RST_VAL;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		for (k = 0; k < 200 && por_done !== 1'b1; k++)
			@(negedge core_clk);
		tmo(k);
		chk(32'(k >= PCYC - 1), 32'h1);
		for (k = 0; k < 200 && sys_in_reset !== 1'b0; k++)
			@(negedge core_clk);
		tmo(k);
		chk(32'(k >= (RCYC - 1) * RDIV && k <= RCYC * RDIV + 9), 32'h1);
		rd(LEG, v);
		chk(v, 32'h7B);
		rd(PIX, v);
		chk(v, PIXEL_CFG_RST_VAL);
	endtask : reset_seq
	initial begin
		reset_seq();
		for (int i = 0; i < 4; i++) begin
			v = xs();
			wr(LEG, v);
			wr(PIX, v);
			wr(8'h10, v);
			rd(LEG, cfg);
			chk(cfg, {24'h0, v[7:0]});
			rd(PIX, cfg);
			chk(cfg, v & PC_WMASK);
			rd(8'h10, cfg);
			chk(cfg, 32'h0);
		end
		for (int c = 0; c < 8; c++) begin
			wr(LEG, {29'h0, 3'(c)});
			repeat (20) @(negedge core_clk);
			tog(80);
			k = c == 0 ? 0 : 160 / (c + 1);
			chk(32'(tl >= k - 2 && tl <= k + 2), 32'h1);
			chk({31'h0, leg_inv}, 32'(c == 0));
			rd(STATUS_OFF, v);
			chk(v & 32'h3, 32'(c == 0));
		end
		for (int i = 0; i < 8; i++) begin
			v = xs();
			wr(PIX, {3'h0, pc[i % 4], v[23:12], 1'(i), 8'h00, 3'(i)});
			@(negedge core_clk);
			fd = 2 * int'(v[22:12]) + int'(v[23]);
			chk({28'h0, p_id}, 32'(i + 2));
			chk({20'h0, p_fd}, 32'(fd));
			chk({27'h0, p_pd}, 32'(pe[i % 4]));
			chk({31'h0, p_run}, {31'h0, m_run(m_pix)});
		end
		for (int i = 0; i < 2; i++) begin
			fd = 2 + 3 * i;
			cfg = 32'h07000801 | (32'(i + 1) << 12) | (32'(i) << 23);
			wr(PIX, cfg | 32'h80000100);
			repeat (50) @(negedge core_clk);
			wr(PIX, cfg | 32'h00000100);
			wr(PIX, cfg);
			repeat (50) @(negedge core_clk);
			tog(RDIV * 100);
			k = 100 * fd / 6;
			chk(32'(tp >= k - 3 && tp <= k + 3), 32'h1);
		end
		wr(PIX, cfg | 32'h80000000);
		repeat (10) @(negedge core_clk);
		tog(100);
		chk(32'(tp), 32'h0);
		wr(PIX, cfg | 32'h00000100);
		tog(RDIV * 100);
		chk(32'(tp >= 196 && tp <= 202), 32'h1);
		reset_seq();
		stop_test();
	end
endmodule : testbench
